// [gsp_serial_port.sv]
// Serial master port with pin-function control for pins seven and eight.
// Assumes an APB master on pclk and asynchronous pad inputs.
//
// Function
// RQ1 - decode pin eight function field, eight codes
// RQ2 - fault select: pin eight low drives alarm
// RQ3 - master enable makes pin seven the clock
// RQ4 - polarity bit sets clock idle level
// RQ5 - phase bit picks leading or trailing sample
// RQ6 - length code zero is 24, else code
// RQ7 - codes above 23 give 23 bits
// RQ8 - select output follows select bit, reset high
// RQ9 - writing execute starts transfer, bit self-clears
// RQ10 - transmit bits go out LSB first
// RQ11 - received bits fill from LSB upward
// RQ12 - peripheral accepts mosi, returns miso data
// RQ13 - master enable overrides pins four to seven
// RQ14 - pins four, five, six: select, miso, mosi
// RQ15 - execute clears after receive bytes update
`timescale 1ns/10ps
module gsp_serial_port
    import gsp_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES,
    parameter int DEPTH       = FIFO_DEPTH
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output wire logic        pready,
    output wire logic [31:0] prdata,
    output wire logic        pslverr,
    input  wire logic [4:0]  pin_in,
    output      gsp_pin_type pin4,
    output      gsp_pin_type pin5,
    output      gsp_pin_type pin6,
    output      gsp_pin_type pin7,
    output      gsp_pin_type pin8,
    output wire logic        fault_alarm_out_n
);
    if (HALF_CYCLES < 4 || HALF_CYCLES > 255)
    begin
        $error("gsp_serial_port: HALF_CYCLES must be 4..255");
    end

    localparam int CW = $bits(gsp_cmd_type);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    typedef struct packed {
        gsp_state_type state;
        gsp_cmd_type   cmd;
        logic [4:0]    bit_idx;
        logic [4:0]    last_idx;
        logic [7:0]    hcnt;
        logic [23:0]   rx_sr;
        logic [23:0]   rx;
        logic [23:0]   tx;
        logic [7:0]    pin78;
        logic [7:0]    fmt;
        logic          fault_sel;
        logic          spi_en;
        logic          ss_ctrl;
        logic          sclk;
        logic          mosi;
        logic          fault_n;
        logic [31:0]   prdata;
    } gsp_port_state_type;

    gsp_port_state_type r_q;
    gsp_port_state_type r_d;

    logic [4:0]  pin_s;
    logic        miso;
    logic [10:0] idx;
    logic        wr_acc;
    logic        go_wr;
    logic        push_ready;
    logic        pop_valid;
    logic        pop_ready;
    gsp_cmd_type push_cmd;
    gsp_cmd_type pop_cmd;
    logic        busy;

    // ----------------------------------------------------------------
    // Pad input synchronisers
    // ----------------------------------------------------------------
    gsp_sync #(.W(5)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pin_in),
        .dout    (pin_s)
    );

    assign miso = pin_s[1]; // RQ14

    // ----------------------------------------------------------------
    // Queued transfer commands
    // ----------------------------------------------------------------
    gsp_fifo #(.W(CW), .DEPTH(DEPTH)) u_fifo
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (go_wr),
        .in_ready  (push_ready),
        .in_data   (push_cmd),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_cmd)
    );

    // Address decode helper
    function automatic logic is_mapped(input logic [10:0] i);
        if (i == IDX_PIN_CTL || i == IDX_PIN78 || i == IDX_FMT)
            return 1'b1;
        else if (i >= IDX_TX1 && i <= IDX_EXE)
            return 1'b1;
        else if (i >= IDX_RX1 && i <= IDX_RX3)
            return 1'b1;
        else
            return 1'b0;
    endfunction

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    assign idx    = paddr[12:2];
    assign wr_acc = psel && penable && pwrite && pready;
    assign go_wr  = psel && penable && pwrite && idx == IDX_EXE &&
                    pwdata[EXE_GO]; // RQ9
    assign pready = !(psel && penable && pwrite && idx == IDX_EXE &&
                      pwdata[EXE_GO] && !push_ready);
    assign pslverr = psel && penable && !is_mapped(idx);
    assign prdata  = r_q.prdata;

    // Command snapshot on execute
    assign push_cmd.tx   = r_q.tx;
    assign push_cmd.clock_idle_polarity = r_q.fmt[FMT_CLOCK_IDLE_POLARITY];
    assign push_cmd.sample_edge_select = r_q.fmt[FMT_SAMPLE_EDGE_SELECT];
    assign push_cmd.len  = gsp_len_decode(r_q.fmt[4:0]); // RQ6 RQ7

    assign busy      = (r_q.state != ST_IDLE);
    assign pop_ready = !busy;

    // ----------------------------------------------------------------
    // Registers, read data and transfer engine
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [23:0] rx_new;
        rx_new = r_q.rx_sr;
        r_d    = r_q;

        // Register writes
        if (wr_acc)
        begin
            if (idx == IDX_PIN_CTL)
            begin
                r_d.fault_sel = pwdata[CTL_FAULT_SEL];
                r_d.spi_en    = pwdata[CTL_SPI_EN];
            end
            else if (idx == IDX_PIN78)
                r_d.pin78 = {2'h0, pwdata[5:0]};
            else if (idx == IDX_FMT)
                r_d.fmt = {1'h0, pwdata[6:0]};
            else if (idx == IDX_TX1)
                r_d.tx[7:0] = pwdata[7:0];
            else if (idx == IDX_TX2)
                r_d.tx[15:8] = pwdata[7:0];
            else if (idx == IDX_TX3)
                r_d.tx[23:16] = pwdata[7:0];
            else if (idx == IDX_EXE)
                r_d.ss_ctrl = pwdata[EXE_SS]; // RQ8
        end

        // Read data captured in the setup phase
        if (psel && !penable)
        begin
            r_d.prdata = 32'h0000_0000;
            if (idx == IDX_PIN_CTL)
                r_d.prdata[7:0] = {r_q.fault_sel, r_q.spi_en, 1'b0, pin_s};
            else if (idx == IDX_PIN78)
                r_d.prdata[7:0] = r_q.pin78;
            else if (idx == IDX_FMT)
                r_d.prdata[7:0] = r_q.fmt;
            else if (idx == IDX_TX1)
                r_d.prdata[7:0] = r_q.tx[7:0];
            else if (idx == IDX_TX2)
                r_d.prdata[7:0] = r_q.tx[15:8];
            else if (idx == IDX_TX3)
                r_d.prdata[7:0] = r_q.tx[23:16];
            else if (idx == IDX_EXE)
                r_d.prdata[7:0] = {6'h00, r_q.ss_ctrl,
                                   busy || pop_valid}; // RQ15
            else if (idx == IDX_RX1)
                r_d.prdata[7:0] = r_q.rx[7:0];
            else if (idx == IDX_RX2)
                r_d.prdata[7:0] = r_q.rx[15:8];
            else if (idx == IDX_RX3)
                r_d.prdata[7:0] = r_q.rx[23:16];
        end

        // Fault input, active low on pin eight
        r_d.fault_n = !(r_q.fault_sel && !pin_s[4]); // RQ2

        // Transfer engine
        case (r_q.state)
            ST_IDLE:
            begin
                r_d.sclk = r_q.fmt[FMT_CLOCK_IDLE_POLARITY]; // RQ4
                if (pop_valid)
                begin
                    r_d.cmd      = pop_cmd;
                    r_d.bit_idx  = 5'h00;
                    r_d.last_idx = pop_cmd.len - 5'h01;
                    r_d.hcnt     = 8'h00;
                    r_d.rx_sr    = 24'h00_0000;
                    r_d.sclk     = pop_cmd.clock_idle_polarity; // RQ4
                    if (!pop_cmd.sample_edge_select)
                        r_d.mosi = pop_cmd.tx[0]; // RQ10
                    r_d.state    = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                r_d.hcnt = r_q.hcnt + 8'h01;
                if (r_q.hcnt == HALF_LAST)
                begin
                    r_d.hcnt  = 8'h00;
                    r_d.sclk  = !r_q.cmd.clock_idle_polarity; // RQ4
                    r_d.state = ST_ACTIVE;
                    if (!r_q.cmd.sample_edge_select)
                        r_d.rx_sr[r_q.bit_idx] = miso; // RQ5 RQ11
                    else
                        r_d.mosi = r_q.cmd.tx[r_q.bit_idx]; // RQ10
                end
            end
            ST_ACTIVE:
            begin
                r_d.hcnt = r_q.hcnt + 8'h01;
                if (r_q.hcnt == HALF_LAST)
                begin
                    r_d.hcnt = 8'h00;
                    r_d.sclk = r_q.cmd.clock_idle_polarity; // RQ4
                    if (r_q.cmd.sample_edge_select)
                        rx_new[r_q.bit_idx] = miso; // RQ5 RQ11
                    r_d.rx_sr = rx_new;
                    if (r_q.bit_idx == r_q.last_idx)
                    begin
                        r_d.rx    = rx_new; // RQ11 RQ15
                        r_d.state = ST_IDLE;
                    end
                    else
                    begin
                        r_d.bit_idx = r_q.bit_idx + 5'h01;
                        r_d.state   = ST_SETUP;
                        if (!r_q.cmd.sample_edge_select)
                            r_d.mosi = r_q.cmd.tx[r_q.bit_idx + 5'h01];
                    end
                end
            end
            default:
                r_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q         <= '0;
            r_q.ss_ctrl <= EXE_RESET[EXE_SS]; // RQ8
            r_q.fault_n <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    // ----------------------------------------------------------------
    // Pad control
    // ----------------------------------------------------------------
    always_comb
    begin
        gsp_pin_type off;
        off  = gsp_pin_decode(PF_HIZ);
        pin8 = gsp_pin_decode(r_q.pin78[5:3]); // RQ1
        if (r_q.fault_sel)
        begin
            pin8        = off; // RQ2
            pin8.din_en = 1'b1;
        end
        pin7 = gsp_pin_decode(r_q.pin78[2:0]); // RQ3
        pin4 = off;
        pin5 = off;
        pin6 = off;
        if (r_q.spi_en)
        begin
            pin7      = off; // RQ13
            pin7.out  = r_q.sclk; // RQ3
            pin7.oe_n = 1'b0;
            pin4.out  = r_q.ss_ctrl; // RQ14 RQ8
            pin4.oe_n = 1'b0;
            pin5.din_en = 1'b1; // RQ12
            pin6.out  = r_q.mosi; // RQ14
            pin6.oe_n = 1'b0;
        end
    end

    assign fault_alarm_out_n = r_q.fault_n;
endmodule

// [gsp_pkg.sv]
// Package: constants, types and pin decode for the serial port block.
// Assumes a single pclk domain and registers reached by word index over APB.
package gsp_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [10:0] IDX_PIN_CTL  = 11'h00e;
    localparam logic [10:0] IDX_PIN78    = 11'h011;
    localparam logic [10:0] IDX_FMT      = 11'h34d;
    localparam logic [10:0] IDX_TX1      = 11'h34e;
    localparam logic [10:0] IDX_TX2      = 11'h34f;
    localparam logic [10:0] IDX_TX3      = 11'h350;
    localparam logic [10:0] IDX_EXE      = 11'h351;
    localparam logic [10:0] IDX_RX1      = 11'h520;
    localparam logic [10:0] IDX_RX2      = 11'h521;
    localparam logic [10:0] IDX_RX3      = 11'h522;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          CTL_FAULT_SEL = 7;
    localparam int          CTL_SPI_EN    = 6;
    localparam int          FMT_CLOCK_IDLE_POLARITY      = 6;
    localparam int          FMT_SAMPLE_EDGE_SELECT      = 5;
    localparam int          EXE_SS        = 1;
    localparam int          EXE_GO        = 0;
    localparam logic [7:0]  EXE_RESET     = 8'h02;
    localparam logic [4:0]  LEN_FULL      = 5'h18;
    localparam logic [4:0]  LEN_MAX_CODE  = 5'h17;
    localparam int          SCLK_HALF_CYCLES = 8;
    localparam int          FIFO_DEPTH    = 8;

    // ----------------------------------------------------------------
    // Pin function codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PF_HIZ   = 3'h0;
    localparam logic [2:0] PF_RSVD  = 3'h1;
    localparam logic [2:0] PF_ANA   = 3'h2;
    localparam logic [2:0] PF_DIN   = 3'h3;
    localparam logic [2:0] PF_HIGH  = 3'h4;
    localparam logic [2:0] PF_LOW   = 3'h5;
    localparam logic [2:0] PF_ANAPU = 3'h6;
    localparam logic [2:0] PF_ANAPD = 3'h7;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE} gsp_state_type;

    typedef struct packed {
        logic [23:0] tx;
        logic        clock_idle_polarity;
        logic        sample_edge_select;
        logic [4:0]  len;
    } gsp_cmd_type;

    typedef struct packed {
        logic out;
        logic oe_n;
        logic ana_en;
        logic din_en;
        logic pull_up;
        logic pull_dn;
    } gsp_pin_type;

    // Pin function field to pad controls
    function automatic gsp_pin_type gsp_pin_decode(input logic [2:0] f);
        gsp_pin_type p;
        p = '{out: 1'b0, oe_n: 1'b1, ana_en: 1'b0, din_en: 1'b0,
              pull_up: 1'b0, pull_dn: 1'b0};
        case (f)
            PF_ANA:   p.ana_en = 1'b1;
            PF_DIN:   p.din_en = 1'b1;
            PF_HIGH:
            begin
                p.out  = 1'b1;
                p.oe_n = 1'b0;
            end
            PF_LOW:   p.oe_n = 1'b0;
            PF_ANAPU:
            begin
                p.ana_en  = 1'b1;
                p.pull_up = 1'b1;
            end
            PF_ANAPD:
            begin
                p.ana_en  = 1'b1;
                p.pull_dn = 1'b1;
            end
            default:  p.oe_n = 1'b1;
        endcase
        return p;
    endfunction

    // Length code to bit count
    function automatic logic [4:0] gsp_len_decode(input logic [4:0] c);
        if (c == 5'h00)
            return LEN_FULL;
        else if (c > LEN_MAX_CODE)
            return LEN_MAX_CODE;
        else
            return c;
    endfunction

endpackage

// [gsp_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/10ps
module gsp_sync
    import gsp_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output wire logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gsp_sync_state_type;

    gsp_sync_state_type r_q;
    gsp_sync_state_type r_d;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = din;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign dout = r_q.s2;
endmodule

// [gsp_fifo.sv]
// Command FIFO with valid/ready on both sides.
// Assumes one clock; depth a power of two.
`timescale 1ns/10ps
module gsp_fifo
    import gsp_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output wire logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output wire logic         out_valid,
    input  wire logic         out_ready,
    output wire logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("gsp_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } gsp_fifo_state_type;

    gsp_fifo_state_type r_q;
    gsp_fifo_state_type r_d;
    logic               full;
    logic               empty;

    // Flags from pointer compare
    assign empty     = (r_q.wp == r_q.rp);
    assign full      = (r_q.wp[AW-1:0] == r_q.rp[AW-1:0]) &&
                       (r_q.wp[AW] != r_q.rp[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = r_q.mem[r_q.rp[AW-1:0]];

    // ----------------------------------------------------------------
    // Push and pop
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        if (in_valid && !full)
        begin
            r_d.mem[r_q.wp[AW-1:0]] = in_data;
            r_d.wp = r_q.wp + 1'b1;
        end
        if (out_ready && !empty)
            r_d.rp = r_q.rp + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_q <= '0;
        else
            r_q <= r_d;
    end
endmodule

// [gsp_serial_port_chk.sv]
// Checker: pin muxing, fault input, serial clock and APB stall rules.
// Assumes a bind into gsp_serial_port; one pclk domain.
`timescale 1ns/10ps
module gsp_serial_port_chk
    import gsp_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [4:0]  pin_in,
    input wire gsp_pin_type pin4,
    input wire gsp_pin_type pin5,
    input wire gsp_pin_type pin6,
    input wire gsp_pin_type pin7,
    input wire gsp_pin_type pin8,
    input wire logic        fault_alarm_out_n
);
    // ------------------------------------------------------------
    // Shadow of control bits
    // ------------------------------------------------------------
    logic        wr, flt, act, fsel_q, spen_q, ss_q, clock_idle_polarity_q;
    logic [10:0] idx;
    int          cnt_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Write decode, fault cause, clock away from idle
    assign wr  = psel && penable && pready && pwrite;
    assign idx = paddr[12:2];
    assign flt = fsel_q && !pin_in[4];
    assign act = spen_q && (pin7.out ^ clock_idle_polarity_q);

    // Track written bits and length of active clock run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fsel_q <= 1'b0;
            spen_q <= 1'b0;
            ss_q   <= 1'b1;
            clock_idle_polarity_q <= 1'b0;
            cnt_q  <= 0;
        end
        else
        begin
            if (wr && idx == IDX_PIN_CTL)
            begin
                fsel_q <= pwdata[CTL_FAULT_SEL];
                spen_q <= pwdata[CTL_SPI_EN];
            end
            if (wr && idx == IDX_EXE)
                ss_q <= pwdata[EXE_SS];
            if (wr && idx == IDX_FMT)
                clock_idle_polarity_q <= pwdata[FMT_CLOCK_IDLE_POLARITY];
            cnt_q <= act ? cnt_q + 1 : 0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_fault_set: assert property (flt [*5] |-> !fault_alarm_out_n)
        else $error("fault output not asserted");
    chk_fault_clr: assert property (!flt [*5] |-> fault_alarm_out_n)
        else $error("fault output without cause");
    chk_pin8_input: assert property (fsel_q |-> pin8.oe_n && pin8.din_en)
        else $error("pin eight not an input");
    chk_sclk_drive: assert property (spen_q |-> !pin7.oe_n)
        else $error("serial clock pin not driven");
    chk_spi_pins: assert property (spen_q |-> !pin4.oe_n && pin5.oe_n
        && !pin6.oe_n)
        else $error("serial pins not assigned");
    chk_ss_level: assert property (spen_q && $stable(ss_q)
        |-> pin4.out == ss_q)
        else $error("select level wrong");
    chk_sclk_pulse: assert property (act |-> cnt_q < HALF_CYCLES)
        else $error("serial clock pulse too long");
    chk_go_stall: assert property (psel && penable && !pready |-> pwrite
        && idx == IDX_EXE && pwdata[EXE_GO])
        else $error("stray wait state");

    cov_fault: cover property (!fault_alarm_out_n);
    cov_stall: cover property (psel && penable && !pready);
    cov_pulse: cover property ($fell(act) ##1 act);
endmodule

bind gsp_serial_port gsp_serial_port_chk #(.HALF_CYCLES(HALF_CYCLES)) chk_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pin_in(pin_in), .pin4(pin4), .pin5(pin5), .pin6(pin6), .pin7(pin7),
    .pin8(pin8), .fault_alarm_out_n(fault_alarm_out_n)
);

// [gsp_spi_peer.sv]
// Peripheral model on the serial pins: captures mosi, returns miso.
// Assumes mode bits and reply word are set before select falls.
`timescale 1ns/10ps
module gsp_spi_peer
(
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        ss,
    input  wire logic        clock_idle_polarity,
    input  wire logic        sample_edge_select,
    input  wire logic [23:0] resp,
    output wire logic        miso,
    output      logic [23:0] got
);
    int   idx = 0;
    logic cur = 1'b0;
    logic lead;

    // Restart the word when selected
    always @(negedge ss)
    begin
        idx = 0;
        cur = resp[0];
    end

    // Sample on the phase edge, present next bit on the other
    always @(sclk)
    begin
        if (ss === 1'b0)
        begin
            lead = (sclk !== clock_idle_polarity);
            if (lead != sample_edge_select)
                got[idx] = mosi;
            if (!lead)
                idx = (idx + 1) % 24;
            if (lead == sample_edge_select)
                cur = resp[idx];
        end
    end

    // Released line shows the inverse of the last bit
    assign miso = (ss === 1'b0) ? cur : ~cur;
endmodule

// [test_gpio_spi_master_port.sv]
// Testbench: register access, pin functions and serial transfers.
// Assumes gsp_serial_port with the peer model on its serial pins.
`timescale 1ns/10ps
module test_gpio_spi_master_port
    import gsp_pkg::*;
();
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        fault_alarm_out_n, flt_lvl, miso, pcpol, pcpha, stalled;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  pin_in;
    gsp_pin_type pin4, pin5, pin6, pin7, pin8;
    logic [23:0] resp, got;
    int          errors = 0;
    int          checks = 0;

    // ------------------------------------------------------------
    // Clock, pad levels, design and peer
    // ------------------------------------------------------------
    always #4 pclk = ~pclk;

    function automatic logic lv(input gsp_pin_type p, input logic e);
        return p.oe_n ? e : p.out;
    endfunction

    // Wire level from each pin's enable
    assign pin_in = {lv(pin8, flt_lvl), lv(pin7, 1'b0), lv(pin6, 1'b0),
                     lv(pin5, miso), lv(pin4, 1'b1)};

    gsp_serial_port dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin4(pin4),
        .pin5(pin5), .pin6(pin6), .pin7(pin7), .pin8(pin8),
        .fault_alarm_out_n(fault_alarm_out_n)
    );

    gsp_spi_peer peer
    (
        .sclk(pin7.out), .mosi(pin6.out), .ss(pin4.oe_n | pin4.out),
        .clock_idle_polarity(pcpol), .sample_edge_select(pcpha), .resp(resp), .miso(miso), .got(got)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; answer taken at the pready edge
    task automatic apb(input logic w, input logic [10:0] i,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {3'h0, i, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            stalled = 1'b1;
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [10:0] i, input logic [7:0] d);
        apb(1'b1, i, d, r, e);
    endtask

    task automatic rd(input logic [10:0] i, input logic [31:0] x);
        apb(1'b0, i, 8'h00, r, e);
        cmp(r, x);
    endtask

    // Poll the start bit until the engine is idle
    task automatic wait_idle;
        int k;
        r = 32'h1;
        for (k = 0; k < 300 && r[0] !== 1'b0; k++)
            apb(1'b0, IDX_EXE, 8'h00, r, e);
        cmp(r, 32'h0);
    endtask

    task automatic xfer(input logic cp, input logic ph, input logic [4:0] c,
                        input logic [23:0] t, input logic [23:0] rs);
        logic [23:0] m, rx;
        int          k;
        k = (c == 5'h00) ? 24 : (c > 5'h17) ? 23 : int'(c);
        m = 24'hffffff >> (24 - k);
        pcpol = cp;
        pcpha = ph;
        resp  = rs;
        for (k = 0; k < 3; k++)
            wr(IDX_TX1 + 11'(k), t[8*k +: 8]);
        wr(IDX_FMT, {1'b0, cp, ph, c});
        wr(IDX_EXE, 8'h01);
        wait_idle();
        for (k = 0; k < 3; k++)
        begin
            apb(1'b0, IDX_RX1 + 11'(k), 8'h00, r, e);
            rx[8*k +: 8] = r[7:0];
        end
        cmp({8'h0, rx}, {8'h0, rs & m});
        cmp({8'h0, got & m}, {8'h0, t & m});
        cmp({31'h0, pin7.out}, {31'h0, cp});
        wr(IDX_EXE, 8'h02);
        cmp({31'h0, pin4.out}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        gsp_pin_type x;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {flt_lvl, stalled, pcpol, pcpha, resp} = {1'b1, 27'h0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_EXE, 32'h2);
        rd(IDX_FMT, 32'h0);
        apb(1'b0, 11'h7ff, 8'h00, r, e);
        cmp({31'h0, e}, 32'h1);
        wr(IDX_RX1, 8'hff);
        rd(IDX_RX1, 32'h0);
        for (int f = 0; f < 8; f++)
        begin
            x = '{out: f == 4, oe_n: f != 4 && f != 5,
                  ana_en: f == 2 || f > 5, din_en: f == 3,
                  pull_up: f == 6, pull_dn: f == 7};
            wr(IDX_PIN78, {2'h0, 3'(f), 3'(f)});
            cmp({26'h0, pin8}, {26'h0, x});
            cmp({26'h0, pin7}, {26'h0, x});
        end
        wr(IDX_PIN_CTL, 8'h80);
        cmp({26'h0, pin8}, 32'h14);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge pclk);
            flt_lvl <= v[0];
            repeat (6) @(negedge pclk);
            cmp({31'h0, fault_alarm_out_n}, 32'(v));
        end
        wr(IDX_PIN_CTL, 8'h40);
        wr(IDX_PIN78, 8'h04);
        cmp({28'h0, pin4.oe_n, pin5.oe_n, pin6.oe_n, pin7.oe_n},
            32'h4);
        xfer(1'b0, 1'b0, 5'h00, 24'ha5c3f1, 24'h3c96e7);
        xfer(1'b1, 1'b1, 5'h01, 24'h000001, 24'hffffff);
        xfer(1'b0, 1'b1, 5'h17, 24'h5a1234, 24'hc0a5e1);
        xfer(1'b1, 1'b0, 5'h1f, 24'hffffff, 24'h81a5e5);
        xfer(1'b0, 1'b0, 5'h18, 24'h0f0f0f, 24'h7e7e7e);
        wr(IDX_FMT, 8'h01);
        stalled = 1'b0;
        repeat (12)
            wr(IDX_EXE, 8'h01);
        cmp({31'h0, stalled}, 32'h1);
        wait_idle();
        end_sim();
    end

    initial
    begin
        #200000;
        errors++;
        end_sim();
    end
endmodule
